/* File: src/dcr_dma_ctrl.sv */
// Purpose: two-channel dma engine: request, arbitration, dual-address transfer, completion
// Assumes: bus and peripheral requests are logic on i_clk; mode inputs change only while masked
// Notes: one unit (read then write) at a time; mask acts between units
`timescale 1ns/100ps
`include "dcr_defines.svh"

// Function
// - when the count runs out, stop the channel and allow its interrupt.
// - bus error response stops the channel's transfer at once and sets its interrupt-request bit.
// - error stop records failing channel and whether read or write failed.
// - mask write suspends the channel only after the current destination write.
// - mask suspension raises no interrupt, keeps completion status; unmasking resumes remaining transfers.
// - normal or error stop sets interrupt-request bit regardless of interrupt mask.
// - cause 0 normal, 1 error; side 0 source error, 1 destination error.
// - count reads 0 after normal stop, remaining transfers after suspension.
// - count decrements only on an error-free source read.
// - each channel has auto or peripheral request mode, chosen by configuration.
// - auto-request channels make their own requests whenever started.
// - peripheral mode takes requests from the one selected request line.
// - all channels come out of reset masked.
// - a completion-clear write clears request, cause and side bits, unless a stop lands in the same cycle.
// - no new transfer on a channel until its completion status is cleared.
// - incrementing addresses hold the next address after the final transfer.
// - fixed priority serves channel 0 first; round-robin demotes the last served.
module dcr_dma_ctrl #(
    parameter int NREQ = 8,
    parameter int SEL_W = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // global mode
    input wire logic i_round_robin,
    // per-channel transfer mode
    input wire logic [`DCR_NCH-1:0] i_auto_req,
    input wire dcr_pkg::dcr_size_type i_size [`DCR_NCH],
    input wire logic [`DCR_NCH-1:0] i_src_inc,
    input wire logic [`DCR_NCH-1:0] i_dst_inc,
    input wire logic [`DCR_NCH-1:0] i_irq_mask_bit,
    input wire logic [SEL_W-1:0] i_request_select [`DCR_NCH],
    // per-channel software writes
    input wire logic [`DCR_NCH-1:0] i_cfg_wr,
    input wire logic [`DCR_ADDR_W-1:0] i_src_addr [`DCR_NCH],
    input wire logic [`DCR_ADDR_W-1:0] i_dst_addr [`DCR_NCH],
    input wire logic [`DCR_COUNT_W-1:0] i_count [`DCR_NCH],
    input wire logic [`DCR_NCH-1:0] i_mask_set,
    input wire logic [`DCR_NCH-1:0] i_mask_clr,
    input wire logic [`DCR_NCH-1:0] i_completion_clear,
    // peripheral requests
    input wire logic [NREQ-1:0] i_periph_req,
    // system bus master
    output logic o_bus_req,
    output logic o_bus_write,
    output logic [`DCR_ADDR_W-1:0] o_bus_addr,
    output logic [`DCR_DATA_W-1:0] o_bus_wdata,
    output dcr_pkg::dcr_size_type o_bus_size,
    input wire logic i_bus_done,
    input wire logic i_bus_err,
    input wire logic [`DCR_DATA_W-1:0] i_bus_rdata,
    // channel status
    output logic [`DCR_ADDR_W-1:0] o_source_addr [`DCR_NCH],
    output logic [`DCR_ADDR_W-1:0] o_dest_addr [`DCR_NCH],
    output logic [`DCR_COUNT_W-1:0] o_transfer_count [`DCR_NCH],
    output logic [`DCR_NCH-1:0] o_channel_mask,
    output logic [`DCR_NCH-1:0] o_irq_request_flag,
    output logic [`DCR_NCH-1:0] o_end_cause_flag,
    output logic [`DCR_NCH-1:0] o_error_side_flag,
    output logic [`DCR_NCH-1:0] o_pending_data_status,
    output logic [`DCR_NCH-1:0] o_irq
);
    import dcr_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [`DCR_ADDR_W-1:0] step_of(input dcr_size_type sz, input logic inc);
        logic [`DCR_ADDR_W-1:0] s;
        s = `DCR_STEP_BYTE;
        if (sz == DCR_SZ_HALF) begin
            s = `DCR_STEP_HALF;
        end else if (sz == DCR_SZ_WORD) begin
            s = `DCR_STEP_WORD;
        end
        return inc ? s : '0;
    endfunction : step_of

    function automatic logic chan_ready(input logic masked, input logic flag,
            input logic [`DCR_COUNT_W-1:0] cnt, input logic auto_mode, input logic line);
        return !masked && !flag && (cnt != '0) && (auto_mode || line);
    endfunction : chan_ready

    // fixed: channel 0 first; round robin: the one not served last
    function automatic logic arb_pick(input logic rr_mode, input logic last, input logic [`DCR_NCH-1:0] rdy);
        logic p;
        p = !rdy[0];
        if (rr_mode && !last) begin
            p = rdy[1];
        end
        return p;
    endfunction : arb_pick

    // ****************************************
    // channels
    // ****************************************
    logic [`DCR_NCH-1:0] rd_ok, wr_ok, done, err;
    logic err_side;
    logic [`DCR_ADDR_W-1:0] src_q [`DCR_NCH];
    logic [`DCR_ADDR_W-1:0] dst_q [`DCR_NCH];
    logic [`DCR_COUNT_W-1:0] cnt_q [`DCR_NCH];
    logic [`DCR_NCH-1:0] mask_q, irq_q, ready;

    for (genvar c = 0; c < `DCR_NCH; c++) begin : g_ch
        logic [`DCR_ADDR_W-1:0] src_step, dst_step;

        // fixed-address devices step by zero, so one adder serves both kinds
        assign src_step = step_of(i_size[c], i_src_inc[c]);
        assign dst_step = step_of(i_size[c], i_dst_inc[c]);
        dcr_channel u_ch (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_cfg_wr(i_cfg_wr[c]),
            .i_src_addr(i_src_addr[c]),
            .i_dst_addr(i_dst_addr[c]),
            .i_count(i_count[c]),
            .i_mask_set(i_mask_set[c]),
            .i_mask_clr(i_mask_clr[c]),
            .i_clear_wr(i_completion_clear[c]),
            .i_src_step(src_step),
            .i_dst_step(dst_step),
            .i_rd_ok(rd_ok[c]),
            .i_wr_ok(wr_ok[c]),
            .i_done(done[c]),
            .i_err(err[c]),
            .i_err_side(err_side),
            .o_src_addr(src_q[c]),
            .o_dst_addr(dst_q[c]),
            .o_count(cnt_q[c]),
            .o_mask(mask_q[c]),
            .o_irq_request(irq_q[c]),
            .o_end_cause(o_end_cause_flag[c]),
            .o_error_side(o_error_side_flag[c]),
            .o_pending(o_pending_data_status[c])
        );
        // a set completion flag blocks restart until cleared
        assign ready[c] = chan_ready(mask_q[c], irq_q[c], cnt_q[c], i_auto_req[c],
            i_periph_req[i_request_select[c]]);
        assign o_source_addr[c] = src_q[c];
        assign o_dest_addr[c] = dst_q[c];
        assign o_transfer_count[c] = cnt_q[c];
    end

    // ****************************************
    // status outputs
    // ****************************************
    assign o_channel_mask = mask_q;
    assign o_irq_request_flag = irq_q;

    // ****************************************
    // engine
    // ****************************************
    dcr_state_type state_reg, state_next;
    logic ch_reg, ch_next, rr_last_reg, rr_last_next;
    logic req_reg, req_next, wr_reg, wr_next;
    logic [`DCR_ADDR_W-1:0] addr_reg, addr_next;
    logic [`DCR_DATA_W-1:0] data_reg, data_next;
    dcr_size_type size_reg, size_next;
    logic pick;

    always_comb begin
        state_next = state_reg;
        ch_next = ch_reg;
        req_next = req_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        size_next = size_reg;
        rd_ok = '0;
        wr_ok = '0;
        done = '0;
        err = '0;
        err_side = 1'b0;
        pick = arb_pick(i_round_robin, rr_last_reg, ready);
        case (state_reg)
            DCR_ST_IDLE: begin
                // mask is only sampled here, so a running unit always finishes
                if (ready != '0) begin
                    ch_next = pick;
                    req_next = 1'b1;
                    wr_next = 1'b0;
                    addr_next = src_q[pick];
                    size_next = i_size[pick];
                    state_next = DCR_ST_READ;
                end
            end
            DCR_ST_READ: begin
                if (i_bus_err) begin
                    err[ch_reg] = 1'b1;
                    err_side = 1'b0;
                    req_next = 1'b0;
                    state_next = DCR_ST_IDLE;
                end else if (i_bus_done) begin
                    rd_ok[ch_reg] = 1'b1;
                    data_next = i_bus_rdata;
                    wr_next = 1'b1;
                    addr_next = dst_q[ch_reg];
                    state_next = DCR_ST_WRITE;
                end
            end
            DCR_ST_WRITE: begin
                if (i_bus_err) begin
                    err[ch_reg] = 1'b1;
                    err_side = 1'b1;
                    req_next = 1'b0;
                    wr_next = 1'b0;
                    state_next = DCR_ST_IDLE;
                end else if (i_bus_done) begin
                    wr_ok[ch_reg] = 1'b1;
                    done[ch_reg] = (cnt_q[ch_reg] == '0);
                    req_next = 1'b0;
                    wr_next = 1'b0;
                    state_next = DCR_ST_IDLE;
                end
            end
            default: begin
                req_next = 1'b0;
                wr_next = 1'b0;
                state_next = DCR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= DCR_ST_IDLE;
            ch_reg <= 1'b0;
            req_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= `DCR_ADDR_RST;
            data_reg <= '0;
            size_reg <= DCR_SZ_BYTE;
        end else begin
            state_reg <= state_next;
            ch_reg <= ch_next;
            req_reg <= req_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            size_reg <= size_next;
        end
    end

    // ****************************************
    // round-robin pointer
    // ****************************************
    // only a finished unit demotes its channel; an error leaves the order alone
    always_comb begin
        rr_last_next = rr_last_reg;
        if (wr_ok != '0) begin
            rr_last_next = ch_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // channel 1 counts as last served, so channel 0 leads after reset
            rr_last_reg <= 1'b1;
        end else begin
            rr_last_reg <= rr_last_next;
        end
    end

    // ****************************************
    // interrupt output
    // ****************************************
    logic [`DCR_NCH-1:0] irq_out_reg, irq_out_next;

    always_comb begin
        // registered so the output is glitch free; status sets regardless of mask
        irq_out_next = irq_q & ~i_irq_mask_bit;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_out_reg <= '0;
        end else begin
            irq_out_reg <= irq_out_next;
        end
    end

    // ****************************************
    // bus outputs
    // ****************************************
    assign o_bus_req = req_reg;
    assign o_bus_write = wr_reg;
    assign o_bus_addr = addr_reg;
    assign o_bus_wdata = data_reg;
    assign o_bus_size = size_reg;
    assign o_irq = irq_out_reg;

endmodule : dcr_dma_ctrl

/* File: src/dcr_defines.svh */
// Purpose: shared constants of the dma completion/request block
// Assumes: included by its bare name
// Notes: widths, channel count, reset values and step sizes only
`ifndef DCR_DEFINES_SVH
`define DCR_DEFINES_SVH

// ****************************************
// widths and channel count
// ****************************************
`define DCR_ADDR_W 32
`define DCR_DATA_W 32
`define DCR_COUNT_W 17
`define DCR_NCH 2

// ****************************************
// reset values
// ****************************************
`define DCR_MASK_RST 1'b1
`define DCR_ADDR_RST 32'h0000_0000
`define DCR_COUNT_RST 17'h0_0000

// ****************************************
// address steps per transfer size
// ****************************************
`define DCR_STEP_BYTE 32'h0000_0001
`define DCR_STEP_HALF 32'h0000_0002
`define DCR_STEP_WORD 32'h0000_0004

`endif

/* File: src/dcr_pkg.sv */
// Purpose: types of the dma completion/request block
// Assumes: dcr_defines.svh on the include path
// Notes: encodings of size follow the bus size field
package dcr_pkg;

// ****************************************
// types
// ****************************************
typedef enum logic [1:0] {
    DCR_SZ_BYTE = 2'h0,
    DCR_SZ_HALF = 2'h1,
    DCR_SZ_WORD = 2'h2
} dcr_size_type;

typedef enum logic [1:0] {
    DCR_ST_IDLE,
    DCR_ST_READ,
    DCR_ST_WRITE
} dcr_state_type;

endpackage : dcr_pkg

/* File: src/dcr_channel.sv */
// Purpose: one dma channel's address, count, mask and completion status
// Assumes: event pulses come from the engine on the same clock
// Notes: all outputs are flops
`timescale 1ns/100ps
`include "dcr_defines.svh"

module dcr_channel (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // software side
    input wire logic i_cfg_wr,
    input wire logic [`DCR_ADDR_W-1:0] i_src_addr,
    input wire logic [`DCR_ADDR_W-1:0] i_dst_addr,
    input wire logic [`DCR_COUNT_W-1:0] i_count,
    input wire logic i_mask_set,
    input wire logic i_mask_clr,
    input wire logic i_clear_wr,
    input wire logic [`DCR_ADDR_W-1:0] i_src_step,
    input wire logic [`DCR_ADDR_W-1:0] i_dst_step,
    // engine events
    input wire logic i_rd_ok,
    input wire logic i_wr_ok,
    input wire logic i_done,
    input wire logic i_err,
    input wire logic i_err_side,
    // state
    output logic [`DCR_ADDR_W-1:0] o_src_addr,
    output logic [`DCR_ADDR_W-1:0] o_dst_addr,
    output logic [`DCR_COUNT_W-1:0] o_count,
    output logic o_mask,
    output logic o_irq_request,
    output logic o_end_cause,
    output logic o_error_side,
    output logic o_pending
);
    import dcr_pkg::*;

    logic [`DCR_ADDR_W-1:0] src_reg, src_next, dst_reg, dst_next;
    logic [`DCR_COUNT_W-1:0] cnt_reg, cnt_next;
    logic mask_reg, mask_next, irq_reg, irq_next, cause_reg, cause_next;
    logic side_reg, side_next, pend_reg, pend_next;

    always_comb begin
        src_next = src_reg;
        dst_next = dst_reg;
        cnt_next = cnt_reg;
        mask_next = mask_reg;
        irq_next = irq_reg;
        cause_next = cause_reg;
        side_next = side_reg;
        pend_next = pend_reg;
        if (i_cfg_wr) begin
            src_next = i_src_addr;
            dst_next = i_dst_addr;
            cnt_next = i_count;
        end
        // count and source advance only on a clean read
        if (i_rd_ok) begin
            cnt_next = cnt_reg - 17'h0_0001;
            src_next = src_reg + i_src_step;
        end
        if (i_wr_ok) begin
            dst_next = dst_reg + i_dst_step;
        end
        if (i_mask_clr) begin
            mask_next = 1'b0;
        end
        if (i_mask_set) begin
            mask_next = 1'b1;
            // suspension leaves irq and cause untouched
            pend_next = (cnt_reg != 17'h0_0000);
        end
        if (i_clear_wr) begin
            irq_next = 1'b0;
            cause_next = 1'b0;
            side_next = 1'b0;
        end
        // a stop in the clear cycle wins over the clear
        if (i_done) begin
            irq_next = 1'b1;
            cause_next = 1'b0;
            side_next = 1'b0;
            pend_next = 1'b0;
        end
        if (i_err) begin
            irq_next = 1'b1;
            cause_next = 1'b1;
            side_next = i_err_side;
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_reg <= `DCR_ADDR_RST;
            dst_reg <= `DCR_ADDR_RST;
            cnt_reg <= `DCR_COUNT_RST;
            mask_reg <= `DCR_MASK_RST;
            irq_reg <= 1'b0;
            cause_reg <= 1'b0;
            side_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            src_reg <= src_next;
            dst_reg <= dst_next;
            cnt_reg <= cnt_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            cause_reg <= cause_next;
            side_reg <= side_next;
            pend_reg <= pend_next;
        end
    end

    assign o_src_addr = src_reg;
    assign o_dst_addr = dst_reg;
    assign o_count = cnt_reg;
    assign o_mask = mask_reg;
    assign o_irq_request = irq_reg;
    assign o_end_cause = cause_reg;
    assign o_error_side = side_reg;
    assign o_pending = pend_reg;

endmodule : dcr_channel

/* File: testbench/dcr_dma_ctrl_assertions.sv */
// Purpose: port-level checks of the dma completion/request block
// Assumes: bound to every dcr_dma_ctrl instance
// Notes: channel-blind where the ports cannot say which channel ran
`timescale 1ns/100ps

module dcr_dma_ctrl_assertions (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // software side
    input wire logic [1:0] i_irq_mask_bit,
    input wire logic [1:0] i_mask_set,
    input wire logic [1:0] i_mask_clr,
    input wire logic [1:0] i_completion_clear,
    // bus
    input wire logic i_bus_done,
    input wire logic i_bus_err,
    input wire logic [31:0] i_bus_rdata,
    input wire logic o_bus_req,
    input wire logic o_bus_write,
    input wire logic [31:0] o_bus_wdata,
    // status
    input wire logic [1:0] o_channel_mask,
    input wire logic [1:0] o_irq_request_flag,
    input wire logic [1:0] o_end_cause_flag,
    input wire logic [1:0] o_error_side_flag,
    input wire logic [1:0] o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ****
    // checks
    // ****
    req_hold_a: assert property (o_bus_req && !i_bus_done && !i_bus_err |=> o_bus_req && $stable(o_bus_write))
        else $error("bus request not held");
    rd_wr_a: assert property (o_bus_req && !o_bus_write && i_bus_done && !i_bus_err |=> o_bus_req && o_bus_write
        && o_bus_wdata == $past(i_bus_rdata)) else $error("read not followed by its write");
    err_stop_a: assert property (o_bus_req && i_bus_err |=> !o_bus_req
        && (o_irq_request_flag & o_end_cause_flag) != 2'h0) else $error("error did not stop");
    err_side_a: assert property (o_bus_req && o_bus_write && i_bus_err |=>
        (o_error_side_flag & o_end_cause_flag) != 2'h0) else $error("write error side wrong");
    irq_out_a: assert property (o_irq == $past(o_irq_request_flag & ~i_irq_mask_bit))
        else $error("irq output wrong");
    clear_a: assert property (i_completion_clear[0] && !(o_bus_req && (i_bus_done || i_bus_err)) |=>
        !o_irq_request_flag[0] && !o_end_cause_flag[0] && !o_error_side_flag[0]) else $error("clear failed");
    mask_set_a: assert property (i_mask_set[1] |=> o_channel_mask[1])
        else $error("mask set ignored");
    mask_clr_a: assert property (i_mask_clr[1] && !i_mask_set[1] |=> !o_channel_mask[1])
        else $error("mask clear ignored");
    start_ok_a: assert property ($rose(o_bus_req) |-> $past(~o_channel_mask & ~o_irq_request_flag) != 2'h0)
        else $error("start without ready channel");
endmodule : dcr_dma_ctrl_assertions

bind dcr_dma_ctrl dcr_dma_ctrl_assertions u_chk (.*);

/* File: testbench/dcr_bus_model.sv */
// Purpose: system bus slave answering the engine's accesses
// Assumes: one access at a time, request held until answered
// Notes: read data toggles when not valid so stale values never match
`timescale 1ns/100ps

module dcr_bus_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // access from engine
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [31:0] i_addr,
    // scenario controls
    input wire logic [3:0] i_wait,
    input wire logic i_err_rd,
    input wire logic i_err_wr,
    // answer
    output logic o_done,
    output logic o_err,
    output logic [31:0] o_rdata
);
    logic [3:0] cnt_reg;
    logic fail;

    assign fail = i_write ? i_err_wr : i_err_rd;
    // one pulse per access; rearm once the pulse has been seen
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= 4'h0;
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= 32'h0;
        end else if (o_done || o_err || !i_req || cnt_reg != i_wait) begin
            cnt_reg <= (o_done || o_err || !i_req) ? 4'h0 : cnt_reg + 4'h1;
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= ~o_rdata;
        end else begin
            o_err <= fail;
            o_done <= !fail;
            o_rdata <= i_addr ^ 32'h5a5a_0000;
        end
    end
endmodule : dcr_bus_model

/* File: testbench/dcr_dma_ctrl_bench.sv */
// Purpose: self-checking bench of the dma completion/request block
// Assumes: inputs change at the falling edge
// Notes: one task per scenario
`timescale 1ns/100ps
`include "dcr_defines.svh"

module dcr_dma_ctrl_bench;
    import dcr_pkg::*;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
    logic clk, rst_n = 1'b0, rr = 1'b0, bd, be, er = 1'b0, ew = 1'b0, breq, bw;
    logic [1:0] ar = 2'h3, si = 2'h3, di = 2'h3, irq_mask_bit = 2'h2, cw = 2'h0, ms = 2'h0, mc = 2'h0, cc = 2'h0;
    logic [1:0] mk, fl, ca, sd, pd, irq;
    logic [2:0] rs[2] = '{2{3'h0}};
    logic [31:0] sa[2] = '{2{32'h0}}, da[2] = '{2{32'h0}}, ba, wd, rd, os[2], od[2];
    logic [16:0] cn[2] = '{2{17'h0}}, oc[2];
    logic [7:0] pr = 8'h0;
    logic [3:0] wt = 4'h0;
    dcr_size_type sz[2] = '{2{DCR_SZ_WORD}}, bsz;
    int bad_count = 0, num_checks = 0;

    dcr_dma_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_round_robin(rr), .i_auto_req(ar), .i_size(sz),
        .i_src_inc(si), .i_dst_inc(di), .i_irq_mask_bit(irq_mask_bit), .i_request_select(rs), .i_cfg_wr(cw),
        .i_src_addr(sa), .i_dst_addr(da), .i_count(cn), .i_mask_set(ms), .i_mask_clr(mc),
        .i_completion_clear(cc), .i_periph_req(pr), .o_bus_req(breq), .o_bus_write(bw), .o_bus_addr(ba),
        .o_bus_wdata(wd), .o_bus_size(bsz), .i_bus_done(bd), .i_bus_err(be), .i_bus_rdata(rd),
        .o_source_addr(os), .o_dest_addr(od), .o_transfer_count(oc), .o_channel_mask(mk),
        .o_irq_request_flag(fl), .o_end_cause_flag(ca), .o_error_side_flag(sd), .o_pending_data_status(pd),
        .o_irq(irq));
    dcr_bus_model bus (.i_clk(clk), .i_rst_n(rst_n), .i_req(breq), .i_write(bw), .i_addr(ba), .i_wait(wt),
        .i_err_rd(er), .i_err_wr(ew), .o_done(bd), .o_err(be), .o_rdata(rd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic pulse(ref logic [1:0] s, input logic [1:0] m);
        @(negedge clk) s = m;
        @(negedge clk) s = 2'h0;
    endtask : pulse
    task automatic cfg(input int c, input logic [31:0] s, input logic [31:0] d, input logic [16:0] n);
        @(negedge clk) sa[c] = s;
        da[c] = d;
        cn[c] = n;
        cw[c] = 1'b1;
        @(negedge clk) cw[c] = 1'b0;
    endtask : cfg
    task automatic wstop(input int c);
        for (int i = 0; i < 300 && fl[c] !== 1'b1; i++) @(negedge clk);
        `CHK(fl[c], 1'b1)
    endtask : wstop
    // masking and clearing together leaves a channel idle for new modes
    task automatic fin(input logic [1:0] m);
        @(negedge clk) ms = m;
        cc = m;
        @(negedge clk) ms = 2'h0;
        cc = 2'h0;
    endtask : fin
    task automatic get(output logic [31:0] a);
        for (int i = 0; i < 60 && !(breq === 1'b1 && bw === 1'b0); i++) @(negedge clk);
        a = ba;
        for (int i = 0; i < 60 && breq !== 1'b0; i++) @(negedge clk);
    endtask : get

    task automatic t_normal;
        cfg(0, 32'h1000, 32'h2000, 17'h3);
        pulse(mc, 2'h1);
        wstop(0);
        `CHK({oc[0], ca[0], pd[0]}, 19'h0)
        `CHK({os[0], od[0]}, {32'h100c, 32'h200c})
        @(negedge clk);
        `CHK(irq[0], 1'b1)
        cfg(0, 32'h1000, 32'h2000, 17'h1);
        repeat (10) @(negedge clk);
        `CHK(oc[0], 17'h1)
        pulse(cc, 2'h1);
        `CHK(fl[0], 1'b0)
        wstop(0);
        `CHK(oc[0], 17'h0)
        fin(2'h1);
    endtask : t_normal
    task automatic t_err;
        er = 1'b1;
        cfg(1, 32'h3000, 32'h4000, 17'h4);
        pulse(mc, 2'h2);
        wstop(1);
        @(negedge clk);
        `CHK({ca[1], sd[1], irq[1], pd[1]}, 4'h8)
        `CHK({oc[1], os[1]}, {17'h4, 32'h3000})
        er = 1'b0;
        ew = 1'b1;
        pulse(cc, 2'h2);
        wstop(1);
        `CHK({ca[1], sd[1]}, 2'h3)
        `CHK({oc[1], od[1]}, {17'h3, 32'h4000})
        ew = 1'b0;
        fin(2'h2);
    endtask : t_err
    task automatic t_susp;
        wt = 4'h3;
        si[0] = 1'b0;
        di[0] = 1'b0;
        sz[0] = DCR_SZ_BYTE;
        cfg(0, 32'h5000, 32'h6000, 17'h5);
        pulse(mc, 2'h1);
        for (int i = 0; i < 50 && bw !== 1'b1; i++) @(negedge clk);
        `CHK({bsz, ba, wd}, {DCR_SZ_BYTE, 32'h6000, 32'h5a5a_5000})
        pulse(ms, 2'h1);
        repeat (12) @(negedge clk);
        `CHK({breq, oc[0], fl[0], pd[0]}, {1'b0, 17'h4, 2'h1})
        `CHK(os[0], 32'h5000)
        pulse(mc, 2'h1);
        wstop(0);
        `CHK({oc[0], pd[0]}, 18'h0)
        fin(2'h1);
        wt = 4'h0;
    endtask : t_susp
    task automatic t_per;
        ar[1] = 1'b0;
        sz[1] = DCR_SZ_HALF;
        rs[1] = 3'h5;
        pr = 8'h04;
        cfg(1, 32'h7000, 32'h7800, 17'h1);
        pulse(mc, 2'h2);
        repeat (10) @(negedge clk);
        `CHK(oc[1], 17'h1)
        pr = 8'h20;
        wstop(1);
        `CHK(oc[1], 17'h0)
        `CHK({os[1], od[1]}, {32'h7002, 32'h7802})
        pr = 8'h0;
        fin(2'h2);
        ar[1] = 1'b1;
        sz[1] = DCR_SZ_WORD;
    endtask : t_per
    task automatic t_pri(input logic m, input logic [31:0] x);
        logic [31:0] a, b;
        si = 2'h0;
        rr = m;
        cfg(0, 32'h100, 32'h900, 17'h2);
        cfg(1, 32'h200, 32'h900, 17'h2);
        pulse(mc, 2'h3);
        get(a);
        get(b);
        `CHK({a, a ^ b}, {32'h100, x})
        wstop(0);
        wstop(1);
        fin(2'h3);
    endtask : t_pri

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        `CHK({mk, fl, breq, oc[0]}, {4'hc, 18'h0})
        t_normal();
        t_err();
        t_susp();
        t_per();
        t_pri(1'b0, 32'h0);
        t_pri(1'b1, 32'h300);
        results();
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule : dcr_dma_ctrl_bench
